// ==== sync_burst_sram_port.sv ====
`timescale 1ns/1ps
// How it works
// - every synchronous input is sampled only at the rising edge of clk, and the host keeps them valid there.
// - address, write data, the three chip selects, both strobes, advance and all write enables are sampled inputs.
// - output enable and sleep act on the data bus drivers at once, without a clock edge.
// - a two-bit counter clears at a strobe and steps for the rest of the burst; the strobed low address bits are combined with it.
// - burst order pin high gives interleaved order, low gives linear order.
// - address and chip selects are captured only at an edge where the controller strobe, or the processor strobe with the primary select low, is asserted.
// - later burst addresses come from the counter, which steps only at edges with burst advance asserted.
// - a burst reads as two cycles for the first beat and one cycle for each of the next three.
// - the common data bus is 36 bits over 256K words or 18 bits over 512K words.
module sync_burst_sram_port
    import sync_burst_sram_pkg::*;
#(
    parameter int DATA_W = sync_burst_sram_pkg::WIDE_DATA_W,
    parameter int ADDR_W = sync_burst_sram_pkg::WIDE_ADDR_W,
    parameter int LANES = DATA_W / sync_burst_sram_pkg::LANE_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // address and chip selects
    input wire logic [ADDR_W-1:0] address,
    input wire logic chip_select_primary_n,
    input wire logic chip_select_depth_a,
    input wire logic chip_select_depth_b_n,
    // burst control
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic burstOrder,
    // write control
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_write_n,
    // common data bus, lane k includes its parity_byte_lane bit at the top
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe_n,
    // asynchronous controls
    input wire logic outputEnable_n,
    input wire logic sleep_request,
    // read beat tap stream
    output logic [DATA_W-1:0] tapData,
    output logic tapValid,
    input wire logic tapReady,
    output logic tapStall
);
    import sync_burst_sram_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // low address bits of a beat; interleave needs no carry, linear wraps modulo four
    function automatic logic [1:0] beat_addr(input logic [1:0] start, input logic [1:0] cnt,
                                              input logic interleave);
        logic [1:0] r;
        r = 2'h0;
        if (interleave) begin
            r = start ^ cnt;
        end else begin
            r = 2'(start + cnt);
        end
        return r;
    endfunction

    // byte lane write mask from the write enables
    function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                   input logic [LANES-1:0] bw_n);
        logic [LANES-1:0] m;
        m = '0;
        if (!gw_n) begin
            m = '1;
        end else if (!bwe_n) begin
            m = ~bw_n;
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] memWord;
    logic [ADDR_W-1:0] baseAddr;
    logic [1:0] beatCnt;
    logic selected;
    access_state_t state;
    access_state_t next_state;
    logic orderMeta;
    logic orderSync;

    // ------------------------------------------------------------
    // sampled decode
    // ------------------------------------------------------------
    logic anyStrobe;
    logic procStart;
    logic csMatch;
    logic [LANES-1:0] wrMask;
    logic advance;
    logic [1:0] next_beatCnt;
    logic [ADDR_W-1:0] curAddr;
    logic [ADDR_W-1:0] nextAddr;
    logic [ADDR_W-1:0] wrAddr;
    logic doWrite;
    logic tapInReady;
    logic tapPush;

    // processor strobe is ignored while the primary select is high, so a deselected
    // bank cannot be stolen by a processor cycle meant for another bank
    assign procStart = !proc_addr_strobe_n && !chip_select_primary_n;
    assign anyStrobe = procStart || !ctrl_addr_strobe_n;
    assign csMatch = !chip_select_primary_n && chip_select_depth_a && !chip_select_depth_b_n;
    assign wrMask = lane_mask(global_write_n, byte_write_enable_n, byte_lane_write_n);
    // a full tap buffer holds the counter while it stays full, so no read beat is lost to a stalled tap before the next strobe
    assign advance = !burst_advance_n && !anyStrobe && selected && tapInReady;
    assign tapStall = selected && (state == ST_READ) && !tapInReady;

    assign curAddr = {baseAddr[ADDR_W-1:BURST_CNT_W], beat_addr(baseAddr[1:0], beatCnt, orderSync)};

    // counter value after this edge
    always_comb begin
        next_beatCnt = beatCnt;
        if (anyStrobe) begin
            next_beatCnt = BURST_CNT_RST;
        end else if (advance) begin
            next_beatCnt = 2'(beatCnt + 2'h1);
        end
    end

    // address the data register follows after this edge
    always_comb begin
        nextAddr = curAddr;
        if (anyStrobe) begin
            nextAddr = address;
        end else if (advance) begin
            nextAddr = {baseAddr[ADDR_W-1:BURST_CNT_W], beat_addr(baseAddr[1:0], next_beatCnt, orderSync)};
        end
    end

    // access type for the coming cycle; the controller strobe samples writes at once,
    // the processor strobe always opens as a read and a write follows in later cycles
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE, ST_READ, ST_WRITE: begin
                if (anyStrobe) begin
                    if (!csMatch) begin
                        next_state = ST_IDLE;
                    end else if (!procStart && (wrMask != '0)) begin
                        next_state = ST_WRITE;
                    end else begin
                        next_state = ST_READ;
                    end
                end else if (selected) begin
                    next_state = (wrMask != '0) ? ST_WRITE : ST_READ;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // write target: the strobed address on a controller-started write, else the burst address
    always_comb begin
        wrAddr = curAddr;
        doWrite = 1'b0;
        if (anyStrobe) begin
            wrAddr = address;
            doWrite = !procStart && csMatch && (wrMask != '0);
        end else begin
            doWrite = selected && (wrMask != '0);
        end
    end

    // ------------------------------------------------------------
    // burst order pin synchroniser
    // ------------------------------------------------------------

    // the order pin is static, but it still passes two flops before the counter reads it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            orderMeta <= 1'b0;
            orderSync <= 1'b0;
        end else begin
            orderMeta <= burstOrder;
            orderSync <= orderMeta;
        end
    end

    // ------------------------------------------------------------
    // address and chip select capture
    // ------------------------------------------------------------

    // all sampling is at the rising edge; between strobes the captured address stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baseAddr <= '0;
            selected <= 1'b0;
        end else if (anyStrobe) begin
            baseAddr <= address;
            selected <= csMatch;
        end
    end

    // burst counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            beatCnt <= BURST_CNT_RST;
        end else begin
            beatCnt <= next_beatCnt;
        end
    end

    // access state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // storage array, one write process per byte lane
    // ------------------------------------------------------------

    // storage has no reset, like the array it models; control state and the data register are reset
    generate
        for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
            // each lane keeps its own array, so no two processes write one variable
            logic [LANE_W-1:0] laneMem [0:(1<<ADDR_W)-1];
            always_ff @(posedge clk) begin
                if (doWrite && wrMask[lane]) begin
                    laneMem[wrAddr] <= dataIn[lane*LANE_W +: LANE_W];
                end
            end
            assign memWord[lane*LANE_W +: LANE_W] = laneMem[nextAddr];
        end
    endgenerate

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------

    // the data register loads the word of the address taking effect at this edge, so the
    // host sees it one cycle later: two cycles from strobe to first beat, one per advance
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dataOut <= '0;
        end else if (anyStrobe || advance) begin
            dataOut <= memWord;
        end
    end

    // drivers follow output enable and sleep with no clock in the path; a write sampled at an edge
    // turns them off only from that edge on, so in the write's own cycle they keep the state of the cycle before
    assign dataOe_n = outputEnable_n || sleep_request || (state != ST_READ) || !selected;

    // ------------------------------------------------------------
    // two-entry tap buffer for read beats
    // ------------------------------------------------------------
    logic [DATA_W-1:0] tapMem [0:TAP_DEPTH-1];
    logic tapWrPtr;
    logic tapRdPtr;
    logic [1:0] tapCount;
    logic tapPop;
    logic readBeat;

    // a read beat is delivered at each edge that loads a fresh word during a read; a beat
    // refused by a full buffer stays pending until the buffer takes it or a strobe drops it, since the held counter keeps its word in place meanwhile
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readBeat <= 1'b0;
        end else begin
            readBeat <= ((next_state == ST_READ) && (anyStrobe ? csMatch : advance))
                        || (readBeat && !tapInReady && !anyStrobe);
        end
    end

    assign tapInReady = (tapCount != 2'(TAP_DEPTH));
    assign tapPush = readBeat && tapInReady;
    assign tapPop = tapValid && tapReady;
    assign tapValid = (tapCount != TAP_CNT_RST);
    assign tapData = tapMem[tapRdPtr];

    // entries
    always_ff @(posedge clk) begin
        if (tapPush) begin
            tapMem[tapWrPtr] <= dataOut;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tapWrPtr <= 1'b0;
            tapRdPtr <= 1'b0;
            tapCount <= TAP_CNT_RST;
        end else begin
            if (tapPush) begin
                tapWrPtr <= !tapWrPtr;
            end
            if (tapPop) begin
                tapRdPtr <= !tapRdPtr;
            end
            if (tapPush && !tapPop) begin
                tapCount <= 2'(tapCount + 2'h1);
            end else if (tapPop && !tapPush) begin
                tapCount <= 2'(tapCount - 2'h1);
            end
        end
    end

endmodule

// ==== sync_burst_sram_pkg.sv ====
package sync_burst_sram_pkg;

    // ------------------------------------------------------------
    // organisation
    // ------------------------------------------------------------
    localparam int WIDE_DATA_W = 36;      // 256K x 36 organisation
    localparam int WIDE_ADDR_W = 18;
    localparam int NARROW_DATA_W = 18;    // 512K x 18 organisation
    localparam int NARROW_ADDR_W = 19;
    localparam int LANE_W = 9;            // eight data bits plus one parity bit per lane

    // ------------------------------------------------------------
    // burst counter
    // ------------------------------------------------------------
    localparam int BURST_CNT_W = 2;       // counter covers the two lowest address bits
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    localparam logic [1:0] BURST_LAST = 2'h3;

    // ------------------------------------------------------------
    // beat timing, in clock cycles
    // ------------------------------------------------------------
    localparam int FIRST_BEAT_CYCLES = 2;
    localparam int NEXT_BEAT_CYCLES = 1;

    // ------------------------------------------------------------
    // tap buffer
    // ------------------------------------------------------------
    localparam int TAP_DEPTH = 2;
    localparam logic [1:0] TAP_CNT_RST = 2'h0;

    // ------------------------------------------------------------
    // access states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } access_state_t;

endpackage

// ==== sync_burst_sram_props.sv ====
`timescale 1ns/1ps
module sync_burst_sram_props #(
    parameter int DATA_W = 36
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host controls
    input wire logic chip_select_primary_n,
    input wire logic chip_select_depth_a,
    input wire logic chip_select_depth_b_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic outputEnable_n,
    input wire logic sleep_request,
    // device outputs and tap
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe_n,
    input wire logic [DATA_W-1:0] tapData,
    input wire logic tapValid,
    input wire logic tapReady,
    input wire logic tapStall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // proc strobe is gated by the primary select, so it is not a strobe on its own
    wire logic anyStb = !ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_select_primary_n);
    wire logic sel = !chip_select_primary_n && chip_select_depth_a && !chip_select_depth_b_n;
    wire logic noWr = global_write_n && byte_write_enable_n;
    sequence readStart;
        anyStb && sel && noWr;
    endsequence
    sequence drivePermit;
        !outputEnable_n && !sleep_request;
    endsequence
    oe_off_a: assert property (outputEnable_n || sleep_request |-> dataOe_n) else $error("bus driven while off");
    first_beat_a: assert property (readStart ##1 drivePermit |-> !dataOe_n) else $error("first beat not driven");
    desel_idle_a: assert property (anyStb && !sel |=> dataOe_n) else $error("driven when deselected");
    hold_data_a: assert property (!anyStb && burst_advance_n |=> $stable(dataOut)) else $error("data moved");
    stall_hold_a: assert property (tapStall && !anyStb |=> $stable(dataOut)) else $error("stall not held");
    tap_push_a: assert property (readStart |-> ##[1:3] tapValid) else $error("read beat not buffered");
    tap_hold_a: assert property (tapValid && !tapReady |=> tapValid && $stable(tapData)) else $error("tap lost");
    write_quiet_a: assert property (!ctrl_addr_strobe_n && proc_addr_strobe_n && sel && !global_write_n
        |=> dataOe_n) else $error("driven in write");
endmodule

bind sync_burst_sram_port sync_burst_sram_props #(.DATA_W(DATA_W)) chk (
    .clk(clk), .nrst(nrst), .chip_select_primary_n(chip_select_primary_n),
    .chip_select_depth_a(chip_select_depth_a), .chip_select_depth_b_n(chip_select_depth_b_n),
    .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .global_write_n(global_write_n), .byte_write_enable_n(byte_write_enable_n),
    .outputEnable_n(outputEnable_n), .sleep_request(sleep_request), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .tapData(tapData), .tapValid(tapValid), .tapReady(tapReady), .tapStall(tapStall));

// ==== sram_host_model.sv ====
`timescale 1ns/1ps
module sram_host_model (
    // clock
    input wire logic clk,
    // address, selects and strobes
    output logic [17:0] address,
    output logic chip_select_primary_n,
    output logic chip_select_depth_a,
    output logic chip_select_depth_b_n,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_advance_n,
    // write control and data
    output logic global_write_n,
    output logic byte_write_enable_n,
    output logic [3:0] byte_lane_write_n,
    output logic [35:0] dataIn
);
    // idle bus at time zero
    initial begin
        {address, dataIn} = '0;
        {chip_select_primary_n, chip_select_depth_b_n, chip_select_depth_a} = 3'h1;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
        {global_write_n, byte_write_enable_n, byte_lane_write_n} = 6'h3f;
    end
    // one bus cycle, driven after the falling edge so it is settled at the rising edge; wm 1 global, 2 byte
    task automatic cyc(input logic p, input logic c, input logic v, input logic [1:0] wm, input logic [3:0] lanes,
                       input logic [17:0] a, input logic [35:0] d, input logic sel);
        @(negedge clk);
        proc_addr_strobe_n = !p;
        ctrl_addr_strobe_n = !c;
        burst_advance_n = !v;
        global_write_n = (wm != 2'h1);
        byte_write_enable_n = (wm != 2'h2);
        byte_lane_write_n = lanes;
        chip_select_depth_a = sel;
        // released lines flip so a stale value never reads as good
        address = (p || c) ? a : ~address;
        dataIn = (wm != 2'h0) ? d : ~dataIn;
    endtask
endmodule

// ==== sync_burst_sram_port_bench.sv ====
`timescale 1ns/1ps
module sync_burst_sram_port_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic burstOrder = 1'b0;
    logic outputEnable_n = 1'b0;
    logic sleep_request = 1'b0;
    logic tapReady = 1'b1;
    logic [17:0] address;
    logic chip_select_primary_n, chip_select_depth_a, chip_select_depth_b_n, proc_addr_strobe_n;
    logic ctrl_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n;
    logic [3:0] byte_lane_write_n;
    logic [35:0] dataIn, dataOut, tapData;
    logic dataOe_n, tapValid, tapStall;
    int err_count = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    sram_host_model host (.clk(clk), .address(address), .chip_select_primary_n(chip_select_primary_n),
        .chip_select_depth_a(chip_select_depth_a), .chip_select_depth_b_n(chip_select_depth_b_n),
        .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n), .byte_lane_write_n(byte_lane_write_n), .dataIn(dataIn));
    sync_burst_sram_port dut (.clk(clk), .nrst(nrst), .address(address), .chip_select_primary_n(chip_select_primary_n),
        .chip_select_depth_a(chip_select_depth_a), .chip_select_depth_b_n(chip_select_depth_b_n),
        .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .burstOrder(burstOrder), .global_write_n(global_write_n),
        .byte_write_enable_n(byte_write_enable_n), .byte_lane_write_n(byte_lane_write_n), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe_n(dataOe_n), .outputEnable_n(outputEnable_n), .sleep_request(sleep_request),
        .tapData(tapData), .tapValid(tapValid), .tapReady(tapReady), .tapStall(tapStall));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [35:0] pat(input logic [17:0] a);
        return {4{a[8:0]}} ^ 36'h5a5a5a5a5;
    endfunction
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle();
        host.cyc(0, 0, 0, 2'h0, 4'hf, 18'h0, 36'h0, 1);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // back-to-back controller writes fill one aligned group of four
    task automatic writeGroup(input logic [17:0] base);
        for (int i = 0; i < 4; i++) host.cyc(0, 1, 0, 2'h1, 4'hf, base + 18'(i), pat(base + 18'(i)), 1);
        idle();
    endtask
    // burst from a middle beat so both orders must wrap inside the group
    task automatic readBurst(input logic p, input logic ord, input logic [17:0] a);
        logic [1:0] lo;
        burstOrder = ord;
        repeat (3) idle(); // order pin is resynchronised
        host.cyc(p, !p, 0, 2'h0, 4'hf, a, 36'h0, 1);
        for (int n = 0; n < 4; n++) begin
            lo = ord ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n);
            host.cyc(0, 0, n < 3, 2'h0, 4'hf, a, 36'h0, 1);
            check(dataOut, pat({a[17:2], lo}));
        end
    endtask
    // only lanes 0 and 2 are selected, so lanes 1 and 3 keep old data
    task automatic byteWrite(input logic [17:0] a);
        host.cyc(0, 1, 0, 2'h2, 4'b1010, a, ~pat(a), 1);
        host.cyc(0, 1, 0, 2'h0, 4'hf, a, 36'h0, 1);
        idle();
        check(dataOut, pat(a) ^ 36'h007fc01ff);
    endtask
    task automatic deselect(input logic [17:0] a);
        host.cyc(0, 1, 0, 2'h0, 4'hf, a, 36'h0, 0);
        idle();
        check({35'h0, dataOe_n}, 36'h1);
    endtask
    task automatic asyncOff(input logic [17:0] a);
        host.cyc(0, 1, 0, 2'h0, 4'hf, a, 36'h0, 1);
        idle();
        check({35'h0, dataOe_n}, 36'h0);
        outputEnable_n = 1'b1;
        #1 check({35'h0, dataOe_n}, 36'h1);
        idle();
        outputEnable_n = 1'b0;
        sleep_request = 1'b1;
        #1 check({35'h0, dataOe_n}, 36'h1);
        idle();
        sleep_request = 1'b0;
        #1 check({35'h0, dataOe_n}, 36'h0);
    endtask
    // processor strobe opens as a read; the write data follows one cycle later
    task automatic procWrite(input logic [17:0] a, input logic [35:0] d);
        host.cyc(1, 0, 0, 2'h0, 4'hf, a, 36'h0, 1);
        host.cyc(0, 0, 0, 2'h1, 4'hf, a, d, 1);
        host.cyc(0, 1, 0, 2'h0, 4'hf, a, 36'h0, 1);
        check({35'h0, dataOe_n}, 36'h1);
        idle();
        check(dataOut, d);
    endtask
    // receiver stalls until the buffer refuses, then drains it empty
    task automatic tapFill(input logic [17:0] a);
        int k;
        logic [35:0] held;
        tapReady = 1'b0;
        host.cyc(1, 0, 0, 2'h0, 4'hf, a, 36'h0, 1);
        repeat (4) host.cyc(0, 0, 1, 2'h0, 4'hf, a, 36'h0, 1);
        check({34'h0, tapStall, tapValid}, 36'h3);
        check(tapData, pat(a));
        held = dataOut;
        repeat (2) host.cyc(0, 0, 1, 2'h0, 4'hf, a, 36'h0, 1);
        check(dataOut, held);
        tapReady = 1'b1;
        for (k = 0; k < 20 && tapValid !== 1'b0; k++) idle();
        if (k == 20) begin
            err_count++;
            $display("[ERR] %0t tap never drained", $time);
            end_of_test();
        end
        // three beats were read, so three must leave the buffer: none lost to the stall
        check(36'(k), 36'h3);
        check({35'h0, tapValid}, 36'h0);
    endtask
    // reset for eight cycles, then run each scenario once, the burst read once in each order
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        check(36'($bits(dut.dataOut)), 36'h24);
        writeGroup(18'h00124);
        readBurst(1, 1, 18'h00126);
        readBurst(0, 0, 18'h00127);
        byteWrite(18'h00125);
        deselect(18'h00124);
        asyncOff(18'h00124);
        tapFill(18'h00124);
        procWrite(18'h00126, 36'h9c3a5e71b);
        end_of_test();
    end
endmodule
